// *** shared/gpio_port4_consts.vh ***
// Purpose: constants of the four-pin port shared with the oscillator pins
// Assumes: 32-bit classic wishbone, byte address = 4 * register index
// Notes:   offsets are register indices; data sits in the low byte
`ifndef GPIO_PORT4_CONSTS_VH
`define GPIO_PORT4_CONSTS_VH

// ****************************************************************
// register indices
// ****************************************************************
`define IDX_PIN_OUTPUT_LATCH      14'h0000
`define IDX_PIN_INPUT_DATA        14'h000d
`define IDX_PIN_DIRECTION_CONTROL 14'h0f1a
`define IDX_PIN_PULLUP_CONTROL    14'h0f27
`define IDX_PIN_FUNCTION_SELECT   14'h0f34
`define IDX_SYSTEM_CONTROL_TWO    14'h0f40

// ****************************************************************
// field layout
// ****************************************************************
`define PIN_COUNT                 4
`define HF_OSC_SELECT_BIT         0
`define LF_OSC_SELECT_BIT         2
`define EXT_HF_OSC_ENABLE_BIT     6
`define FUNC_SELECT_WR_MASK       8'h05

// ****************************************************************
// reset values
// ****************************************************************
`define RST_PIN_FIELD             4'h0
`define RST_FUNC_SELECT           8'h00
`define RST_BUS_DATA              32'h0000_0000

`endif

// *** src/pin_sync2.v ***
// Purpose: two-flop synchroniser for one asynchronous pad level
// Assumes: the pad level is slow next to clk_i
// Notes:   only the second flop is read by outside logic
`timescale 1ns/1ns

module pin_sync2 (
  input  wire clk_i,
  input  wire srst_i,
  input  wire async_i,
  output wire sync_o
);

  reg meta_reg;
  reg sync_reg;

  // ****************************************************************
  // synchroniser flops
  // ****************************************************************
  always @(posedge clk_i) begin
    if (srst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

// *** src/osc_shared_gpio_port4.v ***
// Purpose: four-pin general-purpose port whose pins double as oscillator pins
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   oscillator circuits live outside; this block hands pins over, gates the crystal enable and raises the clock-fault reset
`timescale 1ns/1ns
`include "gpio_port4_consts.vh"

module osc_shared_gpio_port4 (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [15:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire [3:0]  pad_in_i,
  output wire [3:0]  pad_out_o,
  output wire [3:0]  pad_oe_o,
  output wire [3:0]  pullup_en_o,
  output wire        hf_osc_select_o,
  output wire        lf_osc_select_o,
  output wire        ext_hf_osc_enable_o,
  output wire        sysclk_reset_o
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg  [3:0]  pin_output_latch_reg;
  reg  [3:0]  pin_direction_control_reg;
  reg  [3:0]  pin_pullup_control_reg;
  reg         hf_osc_select_bit_reg;
  reg         lf_osc_select_bit_reg;
  reg         ext_hf_osc_enable_reg;
  reg         sysclk_reset_reg;
  reg         ack_reg;
  reg  [31:0] dat_reg;
  reg  [31:0] dat_next;
  reg  [3:0]  pad_out_reg;
  reg  [3:0]  pad_oe_reg;
  reg  [3:0]  pullup_en_reg;

  wire [3:0]  pin_level;
  wire [3:0]  osc_owned;
  wire [3:0]  pin_input_data;
  wire [3:0]  pad_out_next;
  wire [3:0]  pad_oe_next;
  wire [3:0]  pullup_en_next;
  wire [13:0] reg_index;
  wire        bus_req;
  wire        bus_take;
  wire        wr_commit;
  wire        lane0;
  wire [7:0]  wr_byte;

  wire        hit_latch;
  wire        hit_input;
  wire        hit_dir;
  wire        hit_pullup;
  wire        hit_func;
  wire        hit_sysctl;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // each register takes one aligned word; the index is the word address
  assign reg_index  = wb_adr_i[15:2];
  assign bus_req    = wb_cyc_i & wb_stb_i;
  // request seen, answer not yet given: read data are captured here
  assign bus_take   = bus_req & ~ack_reg;
  // writes land on the edge where the master samples ack high
  assign wr_commit  = bus_req & ack_reg & wb_we_i;
  assign lane0      = wb_sel_i[0];
  assign wr_byte    = wb_dat_i[7:0];

  assign hit_latch  = (reg_index == `IDX_PIN_OUTPUT_LATCH);
  assign hit_input  = (reg_index == `IDX_PIN_INPUT_DATA);
  assign hit_dir    = (reg_index == `IDX_PIN_DIRECTION_CONTROL);
  assign hit_pullup = (reg_index == `IDX_PIN_PULLUP_CONTROL);
  assign hit_func   = (reg_index == `IDX_PIN_FUNCTION_SELECT);
  assign hit_sysctl = (reg_index == `IDX_SYSTEM_CONTROL_TWO);

  // ****************************************************************
  // bus answer
  // ****************************************************************
  // ack rises one cycle after the request and drops the cycle after
  always @(posedge clk_i) begin
    if (srst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_take;
    end
  end

  always @* begin
    dat_next = `RST_BUS_DATA;
    if (hit_latch) begin
      dat_next[3:0] = pin_output_latch_reg;
    end else if (hit_input) begin
      dat_next[3:0] = pin_input_data;
    end else if (hit_dir) begin
      dat_next[3:0] = pin_direction_control_reg;
    end else if (hit_pullup) begin
      dat_next[3:0] = pin_pullup_control_reg;
    end else if (hit_func) begin
      dat_next[`HF_OSC_SELECT_BIT] = hf_osc_select_bit_reg;
      dat_next[`LF_OSC_SELECT_BIT] = lf_osc_select_bit_reg;
    end else if (hit_sysctl) begin
      dat_next[`EXT_HF_OSC_ENABLE_BIT] = ext_hf_osc_enable_reg;
    end
  end

  // unmapped words answer with zero so software never hangs
  always @(posedge clk_i) begin
    if (srst_i) begin
      dat_reg <= `RST_BUS_DATA;
    end else if (bus_take) begin
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ****************************************************************
  // output latch
  // ****************************************************************
  always @(posedge clk_i) begin
    if (srst_i) begin
      pin_output_latch_reg <= `RST_PIN_FIELD;
    end else if (wr_commit & lane0 & hit_latch) begin
      pin_output_latch_reg <= wr_byte[3:0];
    end
  end

  // ****************************************************************
  // direction control
  // ****************************************************************
  // software must keep pins 0/1 inputs while the high oscillator owns them;
  // the drive logic below masks them anyway so a slip cannot fight the crystal
  always @(posedge clk_i) begin
    if (srst_i) begin
      pin_direction_control_reg <= `RST_PIN_FIELD;
    end else if (wr_commit & lane0 & hit_dir) begin
      pin_direction_control_reg <= wr_byte[3:0];
    end
  end

  // ****************************************************************
  // pull-up control
  // ****************************************************************
  always @(posedge clk_i) begin
    if (srst_i) begin
      pin_pullup_control_reg <= `RST_PIN_FIELD;
    end else if (wr_commit & lane0 & hit_pullup) begin
      pin_pullup_control_reg <= wr_byte[3:0];
    end
  end

  // ****************************************************************
  // function select
  // ****************************************************************
  // only bits 0 and 2 exist; all other bits are dropped on write
  always @(posedge clk_i) begin
    if (srst_i) begin
      hf_osc_select_bit_reg <= 1'b0;
      lf_osc_select_bit_reg <= 1'b0;
    end else if (wr_commit & lane0 & hit_func) begin
      hf_osc_select_bit_reg <= wr_byte[`HF_OSC_SELECT_BIT];
      lf_osc_select_bit_reg <= wr_byte[`LF_OSC_SELECT_BIT];
    end
  end

  // ****************************************************************
  // external oscillator enable and clock-fault reset
  // ****************************************************************
  // enabling the crystal without its pins would stall the clock, so the
  // write is refused and a one-cycle system clock reset is raised instead
  always @(posedge clk_i) begin
    if (srst_i) begin
      ext_hf_osc_enable_reg <= 1'b0;
      sysclk_reset_reg      <= 1'b0;
    end else begin
      sysclk_reset_reg <= 1'b0;
      if (wr_commit & lane0 & hit_sysctl) begin
        if (wr_byte[`EXT_HF_OSC_ENABLE_BIT] & ~hf_osc_select_bit_reg) begin
          sysclk_reset_reg      <= 1'b1;
          ext_hf_osc_enable_reg <= 1'b0;
        end else begin
          ext_hf_osc_enable_reg <= wr_byte[`EXT_HF_OSC_ENABLE_BIT];
        end
      end
    end
  end

  assign ext_hf_osc_enable_o = ext_hf_osc_enable_reg;
  assign sysclk_reset_o      = sysclk_reset_reg;
  assign hf_osc_select_o     = hf_osc_select_bit_reg;
  assign lf_osc_select_o     = lf_osc_select_bit_reg;

  // ****************************************************************
  // pin ownership
  // ****************************************************************
  assign osc_owned[0] = hf_osc_select_bit_reg;
  assign osc_owned[1] = hf_osc_select_bit_reg;
  assign osc_owned[2] = lf_osc_select_bit_reg;
  assign osc_owned[3] = lf_osc_select_bit_reg;

  // ****************************************************************
  // per-pin drive, pull-up and read path
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_pin
      // pads are asynchronous to clk_i
      pin_sync2 u_sync (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .async_i (pad_in_i[gi]),
        .sync_o  (pin_level[gi])
      );

      assign pad_oe_next[gi]    = pin_direction_control_reg[gi]
                                  & ~osc_owned[gi];
      assign pad_out_next[gi]   = pin_output_latch_reg[gi]
                                  & pad_oe_next[gi];
      assign pullup_en_next[gi] = pin_pullup_control_reg[gi]
                                  & ~pin_direction_control_reg[gi]
                                  & ~osc_owned[gi];
      // a driven or oscillator-owned pin reads as zero
      assign pin_input_data[gi] = pin_level[gi]
                                  & ~pin_direction_control_reg[gi]
                                  & ~osc_owned[gi];
    end
  endgenerate

  // ****************************************************************
  // registered pad controls
  // ****************************************************************
  // one flop stage keeps pad outputs glitch free; cost is one cycle latency
  always @(posedge clk_i) begin
    if (srst_i) begin
      pad_out_reg   <= `RST_PIN_FIELD;
      pad_oe_reg    <= `RST_PIN_FIELD;
      pullup_en_reg <= `RST_PIN_FIELD;
    end else begin
      pad_out_reg   <= pad_out_next;
      pad_oe_reg    <= pad_oe_next;
      pullup_en_reg <= pullup_en_next;
    end
  end

  assign pad_out_o   = pad_out_reg;
  assign pad_oe_o    = pad_oe_reg;
  assign pullup_en_o = pullup_en_reg;

endmodule

// *** tb/osc_shared_gpio_port4_assertions.sv ***
// Purpose: bus and pin relations of the four-pin port
// Assumes: classic wishbone, one clock, data in the low byte
// Notes:   ownership masks pins one stage late, so hf and lf checks wait a cycle
`timescale 1ns/1ns
`include "gpio_port4_consts.vh"

module gpio_port4_checker (
  input wire        clk_i,
  input wire        srst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [15:0] wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire [3:0]  pad_out_o,
  input wire [3:0]  pad_oe_o,
  input wire [3:0]  pullup_en_o,
  input wire        hf_osc_select_o,
  input wire        lf_osc_select_o,
  input wire        sysclk_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire commit_edge = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  sequence bad_enable;
    commit_edge && wb_adr_i[15:2] == `IDX_SYSTEM_CONTROL_TWO && wb_dat_i[6] && !hf_osc_select_o;
  endsequence
  sequence dir_write;
    commit_edge && wb_adr_i[15:2] == `IDX_PIN_DIRECTION_CONTROL && !hf_osc_select_o
      && !lf_osc_select_o;
  endsequence
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_dir_to_pins: assert property (dir_write |-> ##2 pad_oe_o == $past(wb_dat_i[3:0], 2))
    else $error("direction write not seen on pin enables");
  a_out_when_driven: assert property ((pad_out_o & ~pad_oe_o) == 4'h0)
    else $error("pin level shown on an undriven pin");
  a_pullup_input_only: assert property ((pullup_en_o & pad_oe_o) == 4'h0)
    else $error("pull-up on a driven pin");
  a_hf_owns_pins: assert property (hf_osc_select_o && $past(hf_osc_select_o) |->
    pad_oe_o[1:0] == 2'b00 && pullup_en_o[1:0] == 2'b00)
    else $error("high osc pins still driven");
  a_lf_owns_pins: assert property (lf_osc_select_o && $past(lf_osc_select_o) |->
    pad_oe_o[3:2] == 2'b00 && pullup_en_o[3:2] == 2'b00)
    else $error("low osc pins still driven");
  a_clock_fault: assert property (bad_enable |=> sysclk_reset_o ##1 !sysclk_reset_o)
    else $error("clock fault reset not pulsed");
  a_fault_cause: assert property ($rose(sysclk_reset_o) |-> !$past(hf_osc_select_o))
    else $error("clock fault reset with high osc selected");
  a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
endmodule

bind osc_shared_gpio_port4 gpio_port4_checker chk (
  .clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
  .pullup_en_o(pullup_en_o), .hf_osc_select_o(hf_osc_select_o),
  .lf_osc_select_o(lf_osc_select_o), .sysclk_reset_o(sysclk_reset_o));

// *** tb/testbench.sv ***
// Purpose: directed register and pin checks of the four-pin port
// Assumes: ack comes within a few cycles of a request
// Notes:   pad inputs need two edges through the synchroniser
`timescale 1ns/1ns
`include "gpio_port4_consts.vh"

module testbench;
  reg         clk_i = 1'b0;
  reg         srst_i = 1'b1;
  reg         cyc = 1'b0;
  reg         stb = 1'b0;
  reg         we = 1'b0;
  reg  [15:0] adr = 16'h0000;
  reg  [31:0] dat = 32'h0000_0000;
  reg  [3:0]  sel = 4'hf;
  reg  [3:0]  pad_in = 4'h0;
  wire [31:0] rdat;
  wire        ack;
  wire [3:0]  pad_out;
  wire [3:0]  pad_oe;
  wire [3:0]  pullup_en;
  wire        hf_sel;
  wire        lf_sel;
  wire        ext_en;
  wire        fault;
  integer     miscompares = 0;
  integer     comparisons = 0;
  integer     cycles = 0;
  integer     i;
  reg  [31:0] q;
  reg  [13:0] idx [0:3];
  reg  [7:0]  msk [0:3];

  always #2 clk_i = ~clk_i;

  osc_shared_gpio_port4 uut (
    .clk_i(clk_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pullup_en_o(pullup_en),
    .hf_osc_select_o(hf_sel), .lf_osc_select_o(lf_sel), .ext_hf_osc_enable_o(ext_en),
    .sysclk_reset_o(fault));

  // ****
  // tasks
  // ****
  task summarize;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("FAIL %0t got %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // one classic cycle; no fixed latency is assumed, the cycle ceiling ends a hang
  task xfer(input w, input [13:0] ix, input [7:0] d);
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {ix, 2'b00};
      dat <= {24'h00_0000, d};
      do begin
        @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask

  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      miscompares = miscompares + 1;
      summarize;
    end
  end

  // ****
  // tests
  // ****
  initial begin
    idx[0] = `IDX_PIN_OUTPUT_LATCH;
    idx[1] = `IDX_PIN_DIRECTION_CONTROL;
    idx[2] = `IDX_PIN_PULLUP_CONTROL;
    idx[3] = `IDX_PIN_FUNCTION_SELECT;
    msk[0] = 8'h0f;
    msk[1] = 8'h0f;
    msk[2] = 8'h0f;
    msk[3] = 8'h05;
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      xfer(0, idx[i], 8'h00);
      check(q, 32'h0000_0000);
      xfer(1, idx[i], 8'hff);
      xfer(0, idx[i], 8'h00);
      check(q, {24'h00_0000, msk[i]});
      xfer(1, idx[i], 8'h00);
    end
    xfer(0, 14'h0100, 8'h00);
    check(q, 32'h0000_0000);
    xfer(1, `IDX_PIN_OUTPUT_LATCH, 8'h0a);
    xfer(1, `IDX_PIN_DIRECTION_CONTROL, 8'h06);
    xfer(1, `IDX_PIN_PULLUP_CONTROL, 8'h0f);
    pad_in <= 4'hf;
    repeat (3) @(posedge clk_i);
    check(32'(pad_oe), 32'h0000_0006);
    check(32'(pad_out), 32'h0000_0002);
    check(32'(pullup_en), 32'h0000_0009);
    xfer(0, `IDX_PIN_INPUT_DATA, 8'h00);
    check(q, 32'h0000_0009);
    pad_in <= 4'h5;
    repeat (3) @(posedge clk_i);
    xfer(0, `IDX_PIN_INPUT_DATA, 8'h00);
    check(q, 32'h0000_0001);
    sel <= 4'he;
    xfer(1, `IDX_PIN_OUTPUT_LATCH, 8'h05);
    sel <= 4'hf;
    xfer(0, `IDX_PIN_OUTPUT_LATCH, 8'h00);
    check(q, 32'h0000_000a);
    pad_in <= 4'hf;
    xfer(1, `IDX_PIN_DIRECTION_CONTROL, 8'h04);
    xfer(1, `IDX_PIN_FUNCTION_SELECT, 8'h05);
    repeat (3) @(posedge clk_i);
    check({30'h0, hf_sel, lf_sel}, 32'h0000_0003);
    check({24'h00_0000, pad_oe, pullup_en}, 32'h0000_0000);
    xfer(0, `IDX_PIN_INPUT_DATA, 8'h00);
    check(q, 32'h0000_0000);
    xfer(1, `IDX_PIN_FUNCTION_SELECT, 8'h01);
    repeat (3) @(posedge clk_i);
    check({24'h00_0000, pad_oe, pullup_en}, 32'h0000_0048);
    xfer(0, `IDX_PIN_INPUT_DATA, 8'h00);
    check(q, 32'h0000_0008);
    xfer(1, `IDX_PIN_FUNCTION_SELECT, 8'h00);
    xfer(1, `IDX_SYSTEM_CONTROL_TWO, 8'h40);
    @(posedge clk_i);
    check({30'h0, fault, ext_en}, 32'h0000_0002);
    @(posedge clk_i);
    check(32'(fault), 32'h0000_0000);
    xfer(0, `IDX_SYSTEM_CONTROL_TWO, 8'h00);
    check(q, 32'h0000_0000);
    xfer(1, `IDX_PIN_FUNCTION_SELECT, 8'h01);
    xfer(1, `IDX_SYSTEM_CONTROL_TWO, 8'h40);
    @(posedge clk_i);
    check({30'h0, fault, ext_en}, 32'h0000_0001);
    xfer(0, `IDX_SYSTEM_CONTROL_TWO, 8'h00);
    check(q, 32'h0000_0040);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    check({20'h0_0000, hf_sel, lf_sel, ext_en, pad_oe, pullup_en, fault}, 32'h0000_0000);
    xfer(0, `IDX_PIN_DIRECTION_CONTROL, 8'h00);
    check(q, 32'h0000_0000);
    summarize;
  end
endmodule
